// file: core/csf_pkg.sv
// Purpose: shared constants and types of the charger status and fault supervisor
// Assumes: 250 MHz system clock; analog comparators deliver logic levels
// Notes:   status codes are {high flag, low flag}, a 1 meaning released
package csf_pkg;

  // ************************************************************
  // clock and switching frequency
  // ************************************************************
  localparam int CLK_HZ     = 250_000_000; // system clock rate
  localparam int FSW_MIN_HZ = 125_000;     // slowest switching rate
  localparam int FSW_MAX_HZ = 2_200_000;   // fastest switching rate
  localparam int FSW_DEF_HZ = 350_000;     // rate with the set pin open
  localparam int PER_W      = 12;          // width of a period count

  // switching period in clk cycles, longest rounds down, least rounds up
  localparam logic [PER_W-1:0] PER_MAX_CYC = PER_W'(CLK_HZ / FSW_MIN_HZ);
  localparam logic [PER_W-1:0] PER_MIN_CYC = PER_W'((CLK_HZ + FSW_MAX_HZ - 1) / FSW_MAX_HZ);
  localparam logic [PER_W-1:0] PER_DEF_CYC = PER_W'(CLK_HZ / FSW_DEF_HZ);

  // ************************************************************
  // external synchronisation
  // ************************************************************
  localparam logic [6:0] SYNC_DET_PERIODS = 7'h70; // 112 periods with an edge
  localparam logic [3:0] SYNC_STOP_IN     = 4'h2;  // idle periods before external
  localparam logic [3:0] SYNC_STOP_OUT    = 4'hA;  // idle periods before internal
  localparam int         SYNC_TOL_LO      = 9;     // 90 percent of nominal
  localparam int         SYNC_TOL_HI      = 11;    // 110 percent of nominal
  localparam int         SYNC_TOL_DEN     = 10;    // tolerance denominator

  // ************************************************************
  // charge timer, in timer oscillator cycles
  // ************************************************************
  localparam int TMR_W    = 22;        // timer counter width
  localparam int FCHG_CYC = 2097151;   // absorption timeout
  localparam int PCHG_CYC = FCHG_CYC / 8; // precharge timeout

  // ************************************************************
  // power-up and status codes
  // ************************************************************
  localparam logic [1:0] POR_SETTLE_CYC = 2'h3; // synchroniser settle time
  localparam logic [1:0] FLAG_OFF       = 2'h3; // both released
  localparam logic [1:0] FLAG_CHARGING  = 2'h2; // low flag pulled
  localparam logic [1:0] FLAG_FLOAT     = 2'h0; // both pulled
  localparam logic [1:0] FLAG_FAULT     = 2'h1; // high flag pulled

  // charge stage reported by the sequencer
  localparam logic [1:0] SEQ_PRE   = 2'h0;
  localparam logic [1:0] SEQ_CC    = 2'h1;
  localparam logic [1:0] SEQ_ABS   = 2'h2;
  localparam logic [1:0] SEQ_FLOAT = 2'h3;

  // supervisor state
  typedef enum logic [2:0] {
    ST_CHECK, ST_OFF, ST_PRE, ST_CC, ST_ABS, ST_FLOAT, ST_FAULT
  } csf_state_t;

endpackage

// file: core/csf_sync.sv
// Purpose: two-stage synchroniser for a bundle of asynchronous levels
// Assumes: each bit is an independent level
// Notes:   the first stage feeds only the second stage
`timescale 1ns/10ps
module csf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // ************************************************************
  // per-bit synchroniser
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q; // first stage, read only by the second
      // two flip-flops per bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_q   <= 1'b0;
          dout[gi] <= 1'b0;
        end else begin
          meta_q   <= din[gi];
          dout[gi] <= meta_q;
        end
      end
    end
  endgenerate

endmodule

// file: core/csf_divider.sv
// Purpose: switching-rate divider giving a one-cycle enable each period
// Assumes: period is at least 2 and held steady by the caller
// Notes:   the count restarts when restart is high
`timescale 1ns/10ps
module csf_divider #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  logic [W-1:0] cnt_q; // cycles into the current period

  // ************************************************************
  // period counter
  // ************************************************************
  // count up and wrap at the last cycle of the period
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q >= period - W'(1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick  <= 1'b0;
    end
  end

endmodule

// file: core/csf_supervisor.sv
// Purpose: status flags, fault latch, temperature suspend, bias select and
//          switching clock supervision of a step-down battery charger
// Assumes: comparator levels arrive on pins; only power-on reset clears faults
// Notes:   status flags are modelled as pull-down enables
//
// Summary of operation
// R01 - off releases both; charging pulls low flag
// R02 - float pulls both; fault or suspend pulls high
// R03 - temperature suspend clears itself, unlike faults
// R04 - pin faults checked once at power-up
// R05 - reference outside window latches a fault
// R06 - feedback below threshold latches a fault
// R07 - latched fault holds until power cycles
// R08 - precharge timer overrun latches faulty battery
// R09 - deep-discharge drop in voltage states latches
// R10 - temperature trip suspends charging, pauses timer
// R11 - resume previous state; timer where it runs
// R12 - exactly one bias regulator, hysteretic choice
// R13 - switching period set from the resistor
// R14 - open set pin gives default rate
// R15 - external clock needs edges over 112 periods
// R16 - in-range external clock: stop two, switch
// R17 - lost external clock: stop ten, internal
// R18 - flags driven as active pull-down enables
`timescale 1ns/10ps
module csf_supervisor
  import csf_pkg::*;
#(
  parameter int PCHG_LIMIT = PCHG_CYC, // precharge timeout in timer cycles
  parameter int FCHG_LIMIT = FCHG_CYC  // absorption timeout in timer cycles
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             charger_on,
  input  wire logic [1:0]       seq_state,
  input  wire logic             rt_short_gnd,
  input  wire logic             gate_short_supply,
  input  wire logic             timer_open,
  input  wire logic             timer_short_gnd,
  input  wire logic             ref_short_gnd,
  input  wire logic             ref_low,
  input  wire logic             ref_high,
  input  wire logic             fb_low,
  input  wire logic             deep_discharge_sense_low,
  input  wire logic             temp_low_limit_trip,
  input  wire logic             temp_high_limit_trip,
  input  wire logic             external_bias_input_hi,
  input  wire logic             external_bias_input_lo,
  input  wire logic             charge_timer_pin,
  input  wire logic             timer_disable,
  input  wire logic             freq_set_sync_pin,
  input  wire logic             freq_set_open,
  input  wire logic [PER_W-1:0] freq_set_period,
  output logic                  status_flag_high_bit_out,
  output logic                  status_flag_high_bit_oe,
  output logic                  status_flag_low_bit_out,
  output logic                  status_flag_low_bit_oe,
  output logic                  external_bias_regulator_en,
  output logic                  internal_bias_regulator_en,
  output logic                  switch_enable,
  output logic                  switch_tick,
  output logic                  ext_clock_active,
  output logic                  fault_latched,
  output logic                  charge_suspended,
  output logic                  abs_timer_done
);

  // ************************************************************
  // input synchronisation
  // ************************************************************
  logic [31:0] raw;  // every pin level
  logic [31:0] syn;  // same levels after two flops
  assign raw = {freq_set_period, freq_set_open, freq_set_sync_pin, timer_disable,
                charge_timer_pin, external_bias_input_lo, external_bias_input_hi,
                temp_high_limit_trip, temp_low_limit_trip, deep_discharge_sense_low,
                fb_low, ref_high, ref_low, ref_short_gnd, timer_short_gnd,
                timer_open, gate_short_supply, rt_short_gnd, seq_state, charger_on};

  csf_sync #(.WIDTH(32)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   (raw),
    .dout  (syn)
  );

  logic             on_s;       // charger enabled
  logic [1:0]       seq_s;      // sequencer stage
  logic             pin_fault;  // any power-up pin fault
  logic             run_fault;  // any continuous fault
  logic             dd_low_s;   // deep-discharge sense low
  logic             temp_bad;   // battery temperature out of range
  logic             bias_hi_s;  // external bias above upper trip
  logic             bias_lo_s;  // external bias below lower trip
  logic             tmr_pin_s;  // timer oscillator level
  logic             tmr_dis_s;  // timer feature disabled
  logic             sync_s;     // external clock level
  logic             fs_open_s;  // set pin unconnected
  logic [PER_W-1:0] fs_per_s;   // resistor-set period
  assign on_s      = syn[0];
  assign seq_s     = syn[2:1];
  assign pin_fault = |syn[7:3];
  assign run_fault = syn[8] | syn[9] | syn[10];
  assign dd_low_s  = syn[11];
  assign temp_bad  = syn[12] | syn[13];
  assign bias_hi_s = syn[14];
  assign bias_lo_s = syn[15];
  assign tmr_pin_s = syn[16];
  assign tmr_dis_s = syn[17];
  assign sync_s    = syn[18];
  assign fs_open_s = syn[19];
  assign fs_per_s  = syn[31:20];

  // ************************************************************
  // charge state and fault latch
  // ************************************************************
  csf_state_t       state_q;     // supervisor state
  logic [1:0]       settle_q;    // power-up settle counter
  logic             susp_q;      // temperature suspend
  logic [TMR_W-1:0] tmr_cnt_q;   // charge timer count
  logic             tmr_prev_q;  // timer pin delayed
  logic             charging;    // in any charging state
  logic             pchg_over;   // precharge timer overrun
  logic             dd_fault;    // deep discharge in a voltage state
  assign charging  = state_q inside {ST_PRE, ST_CC, ST_ABS, ST_FLOAT};
  assign pchg_over = (state_q == ST_PRE) && (tmr_cnt_q > TMR_W'(PCHG_LIMIT));
  assign dd_fault  = (state_q inside {ST_ABS, ST_FLOAT}) && dd_low_s;

  // stage requested by the sequencer
  function automatic csf_state_t stage_of(input logic [1:0] s);
    case (s)
      SEQ_PRE:   stage_of = ST_PRE;
      SEQ_CC:    stage_of = ST_CC;
      SEQ_ABS:   stage_of = ST_ABS;
      default:   stage_of = ST_FLOAT;
    endcase
  endfunction

  // main state; fault has no exit but reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q  <= ST_CHECK;
      settle_q <= '0;
    end else begin
      case (state_q)
        // wait for the synchronisers, then test the pins once
        ST_CHECK: begin
          if (settle_q != POR_SETTLE_CYC) begin
            settle_q <= settle_q + 2'h1;
          end else if (pin_fault) begin
            state_q <= ST_FAULT; // see R04
          end else begin
            state_q <= ST_OFF;
          end
        end
        ST_FAULT: state_q <= ST_FAULT; // see R07
        default: begin
          if (run_fault || pchg_over || dd_fault) begin
            state_q <= ST_FAULT; // see R05 see R06 see R08 see R09
          end else if (!on_s) begin
            state_q <= ST_OFF;
          end else if (!susp_q) begin
            // frozen while suspended so charging resumes where it was
            state_q <= stage_of(seq_s); // see R11
          end
        end
      endcase
    end
  end

  // suspend follows the temperature, never latched
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      susp_q <= 1'b0;
    end else begin
      susp_q <= charging && temp_bad; // see R03 see R10
    end
  end

  // charge timer counts precharge and absorption, pauses on suspend
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tmr_cnt_q  <= '0;
      tmr_prev_q <= 1'b0;
    end else begin
      tmr_prev_q <= tmr_pin_s;
      if (!susp_q && on_s && state_q != stage_of(seq_s)) begin
        tmr_cnt_q <= '0; // stage change restarts the timer
      end else if (state_q inside {ST_PRE, ST_ABS} && !susp_q && !tmr_dis_s
                   && tmr_pin_s && !tmr_prev_q && tmr_cnt_q != '1) begin
        tmr_cnt_q <= tmr_cnt_q + TMR_W'(1); // see R10 see R11
      end
    end
  end

  // ************************************************************
  // status flags and reported levels
  // ************************************************************
  logic [1:0] code; // {high, low}, 1 = released
  always_comb begin
    if (state_q == ST_FAULT || susp_q) begin
      code = FLAG_FAULT; // see R02
    end else if (state_q == ST_FLOAT) begin
      code = FLAG_FLOAT; // see R02
    end else if (charging) begin
      code = FLAG_CHARGING; // see R01
    end else begin
      code = FLAG_OFF; // see R01
    end
  end

  // pull-down enables are registered; pin level is always low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_flag_high_bit_oe <= 1'b0;
      status_flag_low_bit_oe  <= 1'b0;
      fault_latched           <= 1'b0;
      charge_suspended        <= 1'b0;
      abs_timer_done          <= 1'b0;
    end else begin
      status_flag_high_bit_oe <= ~code[1]; // see R18
      status_flag_low_bit_oe  <= ~code[0]; // see R18
      fault_latched           <= state_q == ST_FAULT;
      charge_suspended        <= susp_q;
      abs_timer_done          <= state_q == ST_ABS && tmr_cnt_q > TMR_W'(FCHG_LIMIT);
    end
  end
  assign status_flag_high_bit_out = 1'b0;
  assign status_flag_low_bit_out  = 1'b0;

  // ************************************************************
  // bias regulator select
  // ************************************************************
  // hysteresis between the two trips; one enable is the inverse of the other
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      external_bias_regulator_en <= 1'b0;
    end else if (bias_hi_s) begin
      external_bias_regulator_en <= 1'b1; // see R12
    end else if (bias_lo_s) begin
      external_bias_regulator_en <= 1'b0; // see R12
    end
  end
  assign internal_bias_regulator_en = ~external_bias_regulator_en;

  // ************************************************************
  // switching clock and external synchronisation
  // ************************************************************
  logic [PER_W-1:0] per;        // internal period in clk cycles
  logic             int_tick;   // internal period boundary
  logic             sync_prev_q;// external level delayed
  logic             sync_edge;  // external rising edge
  logic             seen_q;     // edge seen this period
  logic [PER_W:0]   gap_q;      // cycles since the last edge
  logic [PER_W:0]   meas_q;     // last edge-to-edge interval
  logic             in_tol;     // interval within ten percent
  logic [6:0]       good_q;     // consecutive good periods
  logic [3:0]       stop_q;     // idle periods still to wait
  logic             ext_q;      // on the external clock

  // resistor period clamped to the legal range, default when open
  always_comb begin
    if (fs_open_s) begin
      per = PER_DEF_CYC; // see R14
    end else if (fs_per_s < PER_MIN_CYC) begin
      per = PER_MIN_CYC; // see R13
    end else if (fs_per_s > PER_MAX_CYC) begin
      per = PER_MAX_CYC; // see R13
    end else begin
      per = fs_per_s; // see R13
    end
  end

  csf_divider #(.W(PER_W)) u_div (
    .clk     (clk),
    .reset   (reset),
    .restart (state_q == ST_CHECK),
    .period  (per),
    .tick    (int_tick)
  );

  assign sync_edge = sync_s && !sync_prev_q;
  assign in_tol    = 32'(meas_q) * SYNC_TOL_DEN >= 32'(per) * SYNC_TOL_LO
                  && 32'(meas_q) * SYNC_TOL_DEN <= 32'(per) * SYNC_TOL_HI;

  // measure the external clock edge to edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_prev_q <= 1'b0;
      gap_q       <= '0;
      meas_q      <= '0;
    end else begin
      sync_prev_q <= sync_s;
      if (sync_edge) begin
        meas_q <= gap_q;
        gap_q  <= (PER_W+1)'(1);
      end else if (gap_q != '1) begin
        gap_q <= gap_q + (PER_W+1)'(1);
      end
    end
  end

  // per-period edge check, stop windows and clock source
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      seen_q <= 1'b0;
      good_q <= '0;
      stop_q <= '0;
      ext_q  <= 1'b0;
    end else begin
      if (sync_edge) begin
        seen_q <= 1'b1;
      end
      if (int_tick) begin
        seen_q <= sync_edge;
        if (stop_q != '0) begin
          stop_q <= stop_q - 4'h1;
        end
        if (!ext_q) begin
          if (!(seen_q || sync_edge)) begin
            good_q <= '0;
          end else if (good_q != SYNC_DET_PERIODS) begin
            good_q <= good_q + 7'h1; // see R15
          end else if (in_tol && stop_q == '0) begin
            ext_q  <= 1'b1; // see R16
            stop_q <= SYNC_STOP_IN; // see R16
            good_q <= '0;
          end
        end else if (!(seen_q || sync_edge)) begin
          ext_q  <= 1'b0; // see R17
          stop_q <= SYNC_STOP_OUT; // see R17
        end
      end
    end
  end

  // switching runs only while charging and outside a stop window
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      switch_enable    <= 1'b0;
      switch_tick      <= 1'b0;
      ext_clock_active <= 1'b0;
    end else begin
      switch_enable    <= charging && !susp_q && stop_q == '0;
      switch_tick      <= charging && !susp_q && stop_q == '0
                          && (ext_q ? sync_edge : int_tick);
      ext_clock_active <= ext_q;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_FLAG_OFF: assert property (@(posedge clk) disable iff (reset) // see R01
    state_q == ST_OFF && !susp_q |=> !status_flag_high_bit_oe && !status_flag_low_bit_oe)
    else $error("off state must release both flags");
  AST_FLAG_CHG: assert property (@(posedge clk) disable iff (reset) // see R01
    state_q inside {ST_PRE, ST_CC, ST_ABS} && !susp_q
    |=> !status_flag_high_bit_oe && status_flag_low_bit_oe)
    else $error("charging must pull only the low flag");
  AST_FLAG_FLOAT: assert property (@(posedge clk) disable iff (reset) // see R02
    state_q == ST_FLOAT && !susp_q |=> status_flag_high_bit_oe && status_flag_low_bit_oe)
    else $error("float must pull both flags");
  AST_FLAG_FAULT: assert property (@(posedge clk) disable iff (reset) // see R02
    state_q == ST_FAULT || susp_q |=> status_flag_high_bit_oe && !status_flag_low_bit_oe)
    else $error("fault or suspend must pull only the high flag");
  AST_SUSP_CLEAR: assert property (@(posedge clk) disable iff (reset) // see R03
    susp_q && !temp_bad |=> !susp_q)
    else $error("suspend did not clear with temperature back");
  AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (reset) // see R07
    state_q == ST_FAULT |=> state_q == ST_FAULT [*8])
    else $error("latched fault released without reset");
  AST_RUN_FAULT: assert property (@(posedge clk) disable iff (reset) // see R05
    state_q != ST_CHECK && run_fault |=> state_q == ST_FAULT ##1 fault_latched)
    else $error("reference or feedback fault not latched");
  AST_PCHG: assert property (@(posedge clk) disable iff (reset) // see R08
    pchg_over |=> state_q == ST_FAULT)
    else $error("precharge overrun not latched");
  AST_DD: assert property (@(posedge clk) disable iff (reset) // see R09
    dd_fault && !run_fault |=> state_q == ST_FAULT)
    else $error("deep discharge fault not latched");
  AST_TMR_PAUSE: assert property (@(posedge clk) disable iff (reset) // see R10
    susp_q && $past(susp_q) |-> $stable(tmr_cnt_q))
    else $error("timer moved while suspended");
  AST_BIAS: assert property (@(posedge clk) disable iff (reset) // see R12
    external_bias_regulator_en != internal_bias_regulator_en
    and (bias_hi_s |=> external_bias_regulator_en))
    else $error("bias regulator select wrong");
  AST_SYNC_IN: assert property (@(posedge clk) disable iff (reset) // see R16
    $rose(ext_q) |-> stop_q == SYNC_STOP_IN ##1 !switch_enable)
    else $error("no stop window entering external clock");
  AST_SYNC_OUT: assert property (@(posedge clk) disable iff (reset) // see R17
    $fell(ext_q) |-> stop_q == SYNC_STOP_OUT ##1 !switch_enable)
    else $error("no stop window leaving external clock");

endmodule

// file: bench/csf_host_model.sv
// Purpose: host monitor that reads the two open-drain status flags
// Assumes: each flag line has a pull-up on the host board
// Notes:   code is {high line, low line}, a 1 meaning released
`timescale 1ns/10ps
module csf_host_model (
  input  wire logic       hi_oe,
  input  wire logic       hi_out,
  input  wire logic       lo_oe,
  input  wire logic       lo_out,
  output logic      [1:0] code
);
  // a released line rises to the pull-up level, a driven one shows the pin level
  assign code = {hi_oe ? hi_out : 1'b1, lo_oe ? lo_out : 1'b1};
endmodule

// file: bench/tb_csf_supervisor.sv
// Purpose: self-checking bench for the status and fault supervisor
// Assumes: pin faults are held steady across each power-up check
// Notes:   expected flag codes are queued and compared by a monitor
`timescale 1ns/10ps
module tb_csf_supervisor
  import csf_pkg::*;
;
  logic       clk = 0, reset = 1, on = 0, tdis = 1, tpin = 0, ext_x = 0;
  logic       rl = 0, rh = 0, fbl = 0, ddl = 0, tlo = 0, thi = 0, bhi = 0, blo = 0;
  logic [1:0] seq = SEQ_PRE;
  logic [4:0] pf = 5'h00;
  logic       hoe, hout, loe, lout, exten, inten;
  logic       flt, susp, swen, eact, atd;
  // external clock pin, set-pin state and the expectations that follow them
  logic       sync = 0, sync_run = 0, fopen = 1, stop_x = 0, ea_x = 0, atd_x = 0;
  logic [PER_W-1:0] fper = PER_DEF_CYC;
  logic [1:0] code;
  logic [8:0] expq[$];
  int         error_cnt = 0;
  int         num_checks = 0;
  event       smp;
  csf_supervisor #(.PCHG_LIMIT(8), .FCHG_LIMIT(64)) dut (
    .clk(clk), .reset(reset), .charger_on(on), .seq_state(seq), .rt_short_gnd(pf[0]),
    .gate_short_supply(pf[1]), .timer_open(pf[2]), .timer_short_gnd(pf[3]),
    .ref_short_gnd(pf[4]), .ref_low(rl), .ref_high(rh), .fb_low(fbl),
    .deep_discharge_sense_low(ddl), .temp_low_limit_trip(tlo), .temp_high_limit_trip(thi),
    .external_bias_input_hi(bhi), .external_bias_input_lo(blo), .charge_timer_pin(tpin),
    .timer_disable(tdis), .freq_set_sync_pin(sync), .freq_set_open(fopen),
    .freq_set_period(fper), .status_flag_high_bit_out(hout),
    .status_flag_high_bit_oe(hoe), .status_flag_low_bit_out(lout),
    .status_flag_low_bit_oe(loe), .external_bias_regulator_en(exten),
    .internal_bias_regulator_en(inten), .switch_enable(swen), .switch_tick(),
    .ext_clock_active(eact), .fault_latched(flt), .charge_suspended(susp),
    .abs_timer_done(atd));
  csf_host_model host (.hi_oe(hoe), .hi_out(hout), .lo_oe(loe), .lo_out(lout), .code(code));
  // 250 MHz clock and a slow timer oscillator
  initial forever #2 clk = ~clk;
  always begin
    repeat (8) @(posedge clk);
    #1 tpin = ~tpin;
  end
  // external clock at the shortest period, held low while sync_run is clear
  always begin
    repeat (PER_MIN_CYC / 2) @(posedge clk);
    #1 sync = sync_run & ~sync;
  end
  task automatic chk(string nm, logic [8:0] seen, logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // note the expected bias pair and flag code, then sample once settled
  // the sample is taken a cycle before the driver moves on, so no stimulus races it
  task automatic expect_code(logic [1:0] c);
    expq.push_back({~ext_x, ext_x, c, c == FLAG_FAULT && !(thi | tlo), thi | tlo,
                    (c == FLAG_CHARGING || c == FLAG_FLOAT) && !stop_x, ea_x, atd_x});
    repeat (7) @(posedge clk);
    #1 -> smp;
    @(posedge clk);
    #1;
  endtask
  always @(smp) begin
    chk("bias flags fault suspend switch sync timer",
        {inten, exten, code, flt, susp, swen, eact, atd}, expq.pop_front());
  end
  // power cycle with the given pin faults present
  task automatic power_up(logic [4:0] faults);
    reset = 1;
    pf = faults;
    {on, rl, rh, fbl, ddl, tdis} = 6'h01;
    repeat (8) @(posedge clk);
    #1 reset = 0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    void'($urandom(34));
    power_up(5'h00);
    expect_code(FLAG_OFF);
    on = 1;
    expect_code(FLAG_CHARGING);
    seq = SEQ_FLOAT;
    expect_code(FLAG_FLOAT);
    {thi, tlo} = 2'h1 << ($urandom % 2);
    expect_code(FLAG_FAULT);
    {thi, tlo} = 2'h0;
    expect_code(FLAG_FLOAT);
    bhi = 1;
    ext_x = 1;
    expect_code(FLAG_FLOAT);
    bhi = 0;
    expect_code(FLAG_FLOAT);
    blo = 1;
    ext_x = 0;
    expect_code(FLAG_FLOAT);
    blo = 0;
    seq = SEQ_ABS;
    ddl = 1;
    expect_code(FLAG_FAULT);
    {ddl, on, seq} = 4'h0;
    expect_code(FLAG_FAULT);
    $display("test flags, suspend, bias and latch done");
    for (int i = 0; i < 4; i++) begin
      power_up(5'h00);
      on = 1;
      expect_code(FLAG_CHARGING);
      {fbl, rh, rl} = 3'h1 << i;
      tdis = (i != 3);
      if (i == 3) repeat (200) @(posedge clk);
      expect_code(FLAG_FAULT);
    end
    $display("test continuous and timer faults done");
    power_up(5'h01 << ($urandom % 5));
    on = 1;
    expect_code(FLAG_FAULT);
    power_up(5'h00);
    expect_code(FLAG_OFF);
    pf = 5'h1F;
    on = 1;
    expect_code(FLAG_CHARGING);
    $display("test power-up pin faults done");
    fopen = 0;
    fper = PER_MIN_CYC;
    power_up(5'h00);
    {on, tdis, sync_run} = 3'h5;
    seq = SEQ_ABS;
    repeat (120 * PER_MIN_CYC) @(posedge clk);
    {ea_x, atd_x} = 2'h3;
    expect_code(FLAG_CHARGING);
    sync_run = 0;
    {ea_x, stop_x} = 2'h1;
    repeat (3 * PER_MIN_CYC) @(posedge clk);
    expect_code(FLAG_CHARGING);
    stop_x = 0;
    repeat (12 * PER_MIN_CYC) @(posedge clk);
    expect_code(FLAG_CHARGING);
    $display("test external clock and absorption timer done");
    print_verdict();
  end
endmodule
